// ===== sfe_defs.svh
`ifndef SFE_DEFS_SVH
`define SFE_DEFS_SVH

// ==========================================
// command codes
`define SFE_OPC_QUAD_ON 8'h38
`define SFE_OPC_QUAD_OFF 8'hFF
`define SFE_OPC_PAGE_WIPE 8'h81
`define SFE_OPC_CHIP_WIPE_A 8'h60
`define SFE_OPC_CHIP_WIPE_B 8'hC7

// ==========================================
// configuration and pattern
`define SFE_CFG_LP_BIT 0
`define SFE_LP_PATTERN 8'h34
`define SFE_DTR_LP_CYCLES 5'h04

// ==========================================
// frame lengths in clock edges
`define SFE_SER_OP_EDGES 8'h08
`define SFE_SER_FULL_EDGES 8'h20
`define SFE_QUAD_OP_EDGES 8'h02
`define SFE_QUAD_FULL_EDGES 8'h08
`define SFE_EDGE_MAX 8'hFF

// ==========================================
// timing
`define SFE_CLK_MHZ 25

`endif

// ===== sfe_pkg.sv
package sfe_pkg;

  // ==========================================
  // types
  typedef enum logic [2:0] {
    WIPE_PAGE,
    WIPE_SECTOR,
    WIPE_HALF_BLOCK,
    WIPE_BLOCK,
    WIPE_CHIP
  } sfe_wipe_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CHECK,
    ST_BUSY
  } sfe_state_t;

endpackage

// ===== sfe_flash_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "sfe_defs.svh"

// Overview of operation
// - config bit0 enables pattern in read dummies
// - pattern follows mode bits, mode bits unchanged
// - pattern is fixed byte 00110100 every read
// - single rate: pattern after mode bits, truncated
// - double rate: eight bits in last four dummies
// - 38H enters four-wire mode only if quad set
// - entering four-wire mode keeps the write enable latch
// - FFH leaves four-wire mode, state kept
// - 81h plus page address erases 256-byte page
// - sector chosen by address bits down to A12
// - erase rejected unless chip select rises aligned
// - serial erase frames ignore upper io lines
// - erase starts at chip select rise, busy flag
// - protected sector or block is not erased
// - protected half block: no erase, latch cleared
// - block erase clears any addressed 64K block
// - chip erase only with no protection selected
// - opcodes 60 and C7 both erase chip
// - quad enable is status bit S9

module sfe_flash_ctrl #(
  parameter int PAGE_WIPE_US = 1000,
  parameter int SECTOR_WIPE_US = 2000,
  parameter int HALF_BLOCK_WIPE_US = 4000,
  parameter int BLOCK_WIPE_US = 8000,
  parameter int CHIP_WIPE_US = 16000,
  parameter logic [7:0] SECTOR_OPC = 8'h20,
  parameter logic [7:0] HALF_BLOCK_OPC = 8'h52,
  parameter logic [7:0] BLOCK_OPC = 8'hD8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out_r,
  output logic [3:0] io_out_fall_r,
  output logic [3:0] io_oe_r,
  input wire logic [7:0] config_reg,
  input wire logic [15:0] status_reg,
  input wire logic [4:0] block_protect_field,
  input wire logic rd_dummy_active,
  input wire logic [4:0] rd_dummy_left,
  input wire logic rd_dtr,
  input wire logic [3:0] rd_lane_mask,
  input wire logic wel_set,
  input wire logic wel_clr,
  input wire logic region_locked,
  output logic quad_command_mode_r,
  output logic write_enable_latch_r,
  output logic write_in_progress_r,
  output logic wipe_start_r,
  output sfe_pkg::sfe_wipe_t wipe_kind_r,
  output logic [23:0] wipe_addr_r
);
  import sfe_pkg::*;

  localparam int QE_BIT = 9;
  localparam int PAGE_CYC = PAGE_WIPE_US * `SFE_CLK_MHZ;
  localparam int SECTOR_CYC = SECTOR_WIPE_US * `SFE_CLK_MHZ;
  localparam int HALF_BLOCK_CYC = HALF_BLOCK_WIPE_US * `SFE_CLK_MHZ;
  localparam int BLOCK_CYC = BLOCK_WIPE_US * `SFE_CLK_MHZ;
  localparam int CHIP_CYC = CHIP_WIPE_US * `SFE_CLK_MHZ;

  // ==========================================
  // link side: frame capture on sclk
  logic fresh_r;
  logic [7:0] frm_cnt_r;
  logic [7:0] op_s_r;
  logic [23:0] ad_s_r;
  logic [7:0] op_q_r;
  logic [23:0] ad_q_r;
  wire logic [7:0] idx;
  wire logic [7:0] idx_nxt;

  assign idx = fresh_r ? 8'h00 : frm_cnt_r;
  assign idx_nxt = (idx == `SFE_EDGE_MAX) ? idx : idx + 8'h01;

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      fresh_r <= 1'b1;
    end else begin
      fresh_r <= 1'b0;
    end
  end

  always_ff @(posedge sclk) begin
    frm_cnt_r <= idx_nxt;
  end

  always_ff @(posedge sclk) begin
    if (idx < `SFE_SER_OP_EDGES) begin
      op_s_r <= {op_s_r[6:0], io_in[0]};
    end else if (idx < `SFE_SER_FULL_EDGES) begin
      ad_s_r <= {ad_s_r[22:0], io_in[0]};
    end
  end

  always_ff @(posedge sclk) begin
    if (idx < `SFE_QUAD_OP_EDGES) begin
      op_q_r <= {op_q_r[3:0], io_in};
    end else if (idx < `SFE_QUAD_FULL_EDGES) begin
      ad_q_r <= {ad_q_r[19:0], io_in};
    end
  end

  // ==========================================
  // link side: learning pattern
  logic lp_en_s1_r;
  logic lp_en_s2_r;
  logic [3:0] lp_idx_r;
  wire logic [7:0] lp_pat;
  wire logic lp_go;
  wire logic lp_str_go;
  wire logic lp_dtr_go;
  wire logic [2:0] dtr_k;
  wire logic str_bit;
  wire logic dtr_rise_bit;
  wire logic dtr_fall_bit;

  assign lp_pat = `SFE_LP_PATTERN;
  // read path raises dummy flag after mode bits
  assign lp_go = lp_en_s2_r & rd_dummy_active;
  // stop after eight, cut when dummies end
  assign lp_str_go = lp_go & ~rd_dtr & ~lp_idx_r[3];
  assign lp_dtr_go = lp_go & rd_dtr & (rd_dummy_left <= `SFE_DTR_LP_CYCLES) & (rd_dummy_left != 5'h00);
  assign dtr_k = 3'(`SFE_DTR_LP_CYCLES - rd_dummy_left);
  assign str_bit = lp_pat[3'(3'h7 - lp_idx_r[2:0])];
  assign dtr_rise_bit = lp_pat[3'(3'h7 - {dtr_k[1:0], 1'b0})];
  assign dtr_fall_bit = lp_pat[3'(3'h6 - {dtr_k[1:0], 1'b0})];

  always_ff @(posedge sclk) begin
    lp_en_s1_r <= config_reg[`SFE_CFG_LP_BIT];
    lp_en_s2_r <= lp_en_s1_r;
  end

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      lp_idx_r <= 4'h0;
    end else if (!rd_dummy_active) begin
      lp_idx_r <= 4'h0;
    end else if (lp_str_go) begin
      lp_idx_r <= lp_idx_r + 4'h1;
    end
  end

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      io_out_r <= 4'h0;
      io_out_fall_r <= 4'h0;
      io_oe_r <= 4'h0;
    end else if (lp_str_go) begin
      io_out_r <= {4{str_bit}};
      io_out_fall_r <= {4{str_bit}};
      io_oe_r <= rd_lane_mask;
    end else if (lp_dtr_go) begin
      io_out_r <= {4{dtr_rise_bit}};
      io_out_fall_r <= {4{dtr_fall_bit}};
      io_oe_r <= rd_lane_mask;
    end else begin
      io_out_r <= 4'h0;
      io_out_fall_r <= 4'h0;
      io_oe_r <= 4'h0;
    end
  end

  // ==========================================
  // system side: frame end detection
  logic cs_s1_r;
  logic cs_s2_r;
  logic cs_s3_r;
  wire logic frame_end;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
    end else begin
      cs_s1_r <= cs_n;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
    end
  end

  // erase begins at chip select rise
  assign frame_end = cs_s2_r & ~cs_s3_r;

  // ==========================================
  // system side: command decode
  wire logic qm;
  wire logic [7:0] opc;
  wire logic [23:0] adr;
  wire logic aligned;
  wire logic has_op;
  wire logic has_addr;
  wire logic is_page;
  wire logic is_sector;
  wire logic is_half;
  wire logic is_block;
  wire logic is_chip;
  wire logic is_addr_wipe;
  wire logic wipe_ok;
  wire logic [23:0] base_addr;
  wire sfe_wipe_t kind;
  wire logic quad_on;
  wire logic quad_off;

  assign qm = quad_command_mode_r;
  assign opc = qm ? op_q_r : op_s_r;
  assign adr = qm ? ad_q_r : ad_s_r;
  assign aligned = qm ? ~frm_cnt_r[0] : (frm_cnt_r[2:0] == 3'h0);
  assign has_op = frm_cnt_r >= (qm ? `SFE_QUAD_OP_EDGES : `SFE_SER_OP_EDGES);
  assign has_addr = frm_cnt_r >= (qm ? `SFE_QUAD_FULL_EDGES : `SFE_SER_FULL_EDGES);
  assign is_page = opc == `SFE_OPC_PAGE_WIPE;
  assign is_sector = opc == SECTOR_OPC;
  assign is_half = opc == HALF_BLOCK_OPC;
  assign is_block = opc == BLOCK_OPC;
  assign is_chip = (opc == `SFE_OPC_CHIP_WIPE_A) | (opc == `SFE_OPC_CHIP_WIPE_B);
  assign is_addr_wipe = is_page | is_sector | is_half | is_block;
  assign wipe_ok = write_enable_latch_r & aligned & has_op & (is_chip | (is_addr_wipe & has_addr));
  // sector base from A23 down to A12
  // any address inside the 64K block
  assign base_addr = is_page ? {adr[23:8], 8'h00} :
                     is_sector ? {adr[23:12], 12'h000} :
                     is_half ? {adr[23:15], 15'h0000} :
                     is_block ? {adr[23:16], 16'h0000} : 24'h00_0000;
  assign kind = is_page ? WIPE_PAGE :
                is_sector ? WIPE_SECTOR :
                is_half ? WIPE_HALF_BLOCK :
                is_block ? WIPE_BLOCK : WIPE_CHIP;
  // enter only with quad enable set
  assign quad_on = (opc == `SFE_OPC_QUAD_ON) & status_reg[QE_BIT] & has_op & ~qm;
  assign quad_off = (opc == `SFE_OPC_QUAD_OFF) & has_op & qm;

  // ==========================================
  // system side: erase sequencer
  sfe_state_t state_r;
  logic [31:0] timer_r;
  wire logic locked;
  wire logic [31:0] cycles;
  wire logic wipe_done;
  wire logic wel_drop;

  // chip erase needs no protection at all
  assign locked = (wipe_kind_r == WIPE_CHIP) ? (block_protect_field != 5'h00) : region_locked;
  assign cycles = (wipe_kind_r == WIPE_PAGE) ? 32'(PAGE_CYC) :
                  (wipe_kind_r == WIPE_SECTOR) ? 32'(SECTOR_CYC) :
                  (wipe_kind_r == WIPE_HALF_BLOCK) ? 32'(HALF_BLOCK_CYC) :
                  (wipe_kind_r == WIPE_BLOCK) ? 32'(BLOCK_CYC) : 32'(CHIP_CYC);
  assign wipe_done = (state_r == ST_BUSY) & (timer_r <= 32'h0000_0001);
  assign wel_drop = wipe_done | ((state_r == ST_CHECK) & locked) | wel_clr;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      timer_r <= 32'h0000_0000;
      wipe_start_r <= 1'b0;
      wipe_kind_r <= WIPE_PAGE;
      wipe_addr_r <= 24'h00_0000;
      write_in_progress_r <= 1'b0;
    end else begin
      wipe_start_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (frame_end && wipe_ok) begin
            wipe_kind_r <= kind;
            wipe_addr_r <= base_addr;
            state_r <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (locked) begin
            state_r <= ST_IDLE;
          end else begin
            // busy flag raised until the erase timer runs out
            timer_r <= cycles;
            wipe_start_r <= 1'b1;
            write_in_progress_r <= 1'b1;
            state_r <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          timer_r <= timer_r - 32'h0000_0001;
          if (wipe_done) begin
            write_in_progress_r <= 1'b0;
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // latch cleared at end, set wins
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      write_enable_latch_r <= 1'b0;
    end else if (wel_set) begin
      write_enable_latch_r <= 1'b1;
    end else if (wel_drop) begin
      write_enable_latch_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      quad_command_mode_r <= 1'b0;
    end else if (frame_end && state_r == ST_IDLE && quad_on) begin
      quad_command_mode_r <= 1'b1;
    end else if (frame_end && state_r == ST_IDLE && quad_off) begin
      quad_command_mode_r <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ===== sfe_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// host end of the link
module sfe_host_model (
  output logic sclk,
  output logic cs_n,
  output logic [3:0] io_in
);
  initial begin
    {sclk, cs_n, io_in} = 6'h10;
  end
  task automatic sel(input bit on);
    cs_n = !on;
    io_in = ~io_in;
  endtask
  task automatic beat();
    #40 sclk = 1'b1;
    #40 sclk = 1'b0;
  endtask
  task automatic frame(input logic [31:0] d, input int n, input bit quad);
    #7 sel(1);
    for (int i = 0; i < n; i++) begin
      io_in = quad ? d[31-4*i -: 4] : {~io_in[3:1], d[31-i]};
      beat();
    end
    sel(0);
    #300;
  endtask
endmodule
`default_nettype wire

// ===== sfe_flash_ctrl_props.sv
`timescale 1ns/10ps
`default_nettype none
module sfe_flash_ctrl_props (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [4:0] block_protect_field,
  input wire logic region_locked,
  input wire logic quad_command_mode_r,
  input wire logic write_enable_latch_r,
  input wire logic write_in_progress_r,
  input wire logic wipe_start_r,
  input wire sfe_pkg::sfe_wipe_t wipe_kind_r,
  input wire logic [23:0] wipe_addr_r
);
  import sfe_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ==========
  // erase launch
  busy_rise_a: assert property ($rose(write_in_progress_r) |-> wipe_start_r)
    else $error("busy without start");
  busy_hold_a: assert property (wipe_start_r |-> write_in_progress_r [*8])
    else $error("busy too short");
  busy_end_a: assert property ($fell(write_in_progress_r) |-> !write_enable_latch_r)
    else $error("latch kept after erase");
  need_latch_a: assert property (wipe_start_r |-> $past(write_enable_latch_r))
    else $error("erase without latch");
  chip_free_a: assert property (wipe_start_r && wipe_kind_r == WIPE_CHIP |-> block_protect_field == 5'h00)
    else $error("chip erase while protected");
  locked_skip_a: assert property (wipe_start_r && wipe_kind_r != WIPE_CHIP |-> !$past(region_locked))
    else $error("locked region erased");
  sector_base_a: assert property (wipe_start_r && wipe_kind_r == WIPE_SECTOR |-> wipe_addr_r[11:0] == 12'h000)
    else $error("sector base wrong");
  mode_latch_a: assert property ($changed(quad_command_mode_r) |-> $stable(write_enable_latch_r))
    else $error("mode switch moved latch");
  // ==========
  // main scenarios
  cover property (wipe_start_r && wipe_kind_r == WIPE_SECTOR);
  cover property (wipe_start_r && wipe_kind_r == WIPE_CHIP && quad_command_mode_r);
  cover property ($fell(quad_command_mode_r));
endmodule
bind sfe_flash_ctrl sfe_flash_ctrl_props u_props (.ref_clk, .sys_rst, .block_protect_field, .region_locked,
  .quad_command_mode_r, .write_enable_latch_r, .write_in_progress_r, .wipe_start_r, .wipe_kind_r, .wipe_addr_r);
`default_nettype wire

// ===== sfe_flash_ctrl_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "sfe_defs.svh"
module sfe_flash_ctrl_tb_top;
  import sfe_pkg::*;
  logic ref_clk, sys_rst, sclk, cs_n, wel_set, wel_clr, region_locked, rd_dummy_active, rd_dtr;
  logic quad_command_mode_r, write_enable_latch_r, write_in_progress_r, wipe_start_r;
  logic [3:0] io_in, io_out_r, io_out_fall_r, io_oe_r, rd_lane_mask;
  logic [7:0] config_reg;
  logic [15:0] status_reg;
  logic [4:0] block_protect_field, rd_dummy_left;
  logic [23:0] wipe_addr_r;
  sfe_wipe_t wipe_kind_r;
  logic [7:0] pat = `SFE_LP_PATTERN;
  logic [7:0] ops [2] = '{8'h60, 8'hC7};
  int err_total = 0;
  int checks = 0;
  sfe_host_model host (.sclk, .cs_n, .io_in);
  sfe_flash_ctrl #(.PAGE_WIPE_US(1), .SECTOR_WIPE_US(1), .HALF_BLOCK_WIPE_US(1), .BLOCK_WIPE_US(1),
    .CHIP_WIPE_US(1)) dut (.ref_clk, .sys_rst, .sclk, .cs_n, .io_in, .io_out_r, .io_out_fall_r, .io_oe_r,
    .config_reg, .status_reg, .block_protect_field, .rd_dummy_active, .rd_dummy_left, .rd_dtr,
    .rd_lane_mask, .wel_set, .wel_clr, .region_locked, .quad_command_mode_r, .write_enable_latch_r,
    .write_in_progress_r, .wipe_start_r, .wipe_kind_r, .wipe_addr_r);
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // ==========
  // helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic write_enable_latch();
    wel_set = 1'b1;
    cyc(1);
    wel_set = 1'b0;
  endtask
  task automatic run(input logic [31:0] d, input int n, input bit quad, input bit go, input logic [23:0] a,
      input sfe_wipe_t k, input logic wel_end);
    int t;
    host.frame(d, n, quad);
    cyc(2);
    chk("busy", write_in_progress_r, go);
    if (go) begin
      chk("kind", wipe_kind_r, k);
      if (k != WIPE_CHIP) chk("addr", wipe_addr_r, a);
    end
    for (t = 0; t < 60 && write_in_progress_r !== 1'b0; t++) cyc(1);
    if (t == 60) begin
      err_total++;
      close_out();
    end
    if (wel_end !== 1'bx) chk("latch", write_enable_latch_r, wel_end);
  endtask
  // ==========
  // scenarios
  task automatic s_gate();
    run({8'h20, 24'h12_3456}, 32, 0, 0, 0, WIPE_SECTOR, 0);
    write_enable_latch();
    wel_clr = 1'b1;
    cyc(1);
    wel_clr = 1'b0;
    run({8'h20, 24'h12_3456}, 32, 0, 0, 0, WIPE_SECTOR, 0);
    write_enable_latch();
    run({8'h20, 24'h12_3456}, 31, 0, 0, 0, WIPE_SECTOR, 1);
    run({8'h20, 24'h12_3456}, 32, 0, 1, 24'h12_3000, WIPE_SECTOR, 0);
    write_enable_latch();
    run({8'h81, 24'hAB_CDEF}, 32, 0, 1, 24'hAB_CD00, WIPE_PAGE, 0);
  endtask
  task automatic s_prot();
    region_locked = 1'b1;
    write_enable_latch();
    run({8'h52, 24'h01_ABCD}, 32, 0, 0, 0, WIPE_HALF_BLOCK, 0);
    write_enable_latch();
    run({8'hD8, 24'h0A_FFFF}, 32, 0, 0, 0, WIPE_BLOCK, 0);
    region_locked = 1'b0;
    write_enable_latch();
    run({8'h52, 24'h01_ABCD}, 32, 0, 1, 24'h01_8000, WIPE_HALF_BLOCK, 0);
    write_enable_latch();
    run({8'hD8, 24'h0A_FFFF}, 32, 0, 1, 24'h0A_0000, WIPE_BLOCK, 0);
    foreach (ops[i]) begin
      block_protect_field = 5'h04;
      write_enable_latch();
      run({ops[i], 24'h0}, 8, 0, 0, 0, WIPE_CHIP, 0);
      block_protect_field = 5'h00;
      write_enable_latch();
      run({ops[i], 24'h0}, 8, 0, 1, 0, WIPE_CHIP, 0);
    end
  endtask
  task automatic s_quad();
    write_enable_latch();
    host.frame({8'h38, 24'h0}, 8, 0);
    cyc(2);
    chk("quad", quad_command_mode_r, 0);
    status_reg = 16'h0200;
    host.frame({8'h38, 24'h0}, 8, 0);
    cyc(2);
    chk("quad", {quad_command_mode_r, write_enable_latch_r}, 2'h3);
    run({8'hC7, 24'h0}, 2, 1, 1, 0, WIPE_CHIP, 0);
    write_enable_latch();
    host.frame({8'hFF, 24'h0}, 2, 1);
    cyc(2);
    chk("quad", {quad_command_mode_r, write_enable_latch_r}, 2'h1);
  endtask
  task automatic s_pat();
    config_reg = 8'h01;
    rd_lane_mask = 4'h1;
    rd_dummy_left = 5'h08;
    for (int m = 0; m < 2; m++) begin
      rd_lane_mask = m[0] ? 4'hF : 4'h1;
      host.sel(1);
      host.beat();
      host.beat();
      rd_dtr = m[0];
      rd_dummy_active = 1'b1;
      for (int i = 7; i >= 0 && m == 0; i--) begin
        host.beat();
        chk("lp", {io_oe_r, io_out_r[0], io_out_fall_r[0]}, {4'h1, pat[i], pat[i]});
      end
      for (int k = 4; k > 0 && m == 1; k--) begin
        rd_dummy_left = 5'(k);
        host.beat();
        chk("dtr", {io_oe_r, io_out_r[3], io_out_fall_r[3]}, {4'hF, pat[2*k-1], pat[2*k-2]});
      end
      rd_dummy_active = 1'b0;
      host.sel(0);
      #200;
      chk("oe", io_oe_r, 0);
    end
    // pattern disabled: no drive in dummies
    config_reg = 8'h00;
    rd_dtr = 1'b0;
    host.sel(1);
    host.beat();
    host.beat();
    rd_dummy_active = 1'b1;
    host.beat();
    chk("lp_off", io_oe_r, 0);
    rd_dummy_active = 1'b0;
    host.sel(0);
    #200;
  endtask
  initial begin
    {sys_rst, wel_set, wel_clr, region_locked, rd_dummy_active, rd_dtr} = 6'h20;
    {config_reg, status_reg, block_protect_field, rd_dummy_left, rd_lane_mask} = '0;
    cyc(10);
    sys_rst = 1'b0;
    cyc(1);
    chk("reset", {quad_command_mode_r, write_enable_latch_r, write_in_progress_r, wipe_start_r}, 0);
    s_gate();
    s_prot();
    s_quad();
    cyc(1);
    s_pat();
    close_out();
  end
endmodule
`default_nettype wire
